// [ptic_cfg.svh]
// Constants for the pattern trigger and illumination controller
`ifndef PTIC_CFG_SVH
`define PTIC_CFG_SVH
`define PTIC_CLK_HZ          50000000
`define PTIC_BLINK_HALF_MS   250
`define PTIC_BLINK_HALF_CYC  ((`PTIC_CLK_HZ / 1000) * `PTIC_BLINK_HALF_MS)
`define PTIC_PWM_BITS        8
`define PTIC_NUM_CH          3
`define PTIC_CH_RED          0
`define PTIC_CH_GREEN        1
`define PTIC_CH_BLUE         2
`define PTIC_PAT_BITS        8
`define PTIC_EXPOSE_DEF      16'h0100
`define PTIC_GAP_DEF         16'h0010
`define PTIC_NUM_PAT_DEF     8'h08
`endif

// [ptic_pkg.sv]
// Types shared by the pattern trigger and illumination controller
package ptic_pkg;
   typedef enum logic [1:0] {
      PTIC_MODE_STEP = 2'h0,  // In1 advances, in2 pauses
      PTIC_MODE_ALT  = 2'h1   // In1 alternates, in2 advances by two
   } ptic_mode_t;
   typedef enum logic [2:0] {
      PTIC_ST_IDLE   = 3'h1,
      PTIC_ST_EXPOSE = 3'h2,
      PTIC_ST_GAP    = 3'h4
   } ptic_state_t;
endpackage

// [ptic_trig_if.sv]
// Trigger event signals between the input synchroniser and the sequencer
interface ptic_trig_if;
   logic adv_pulse;
   logic pause_pulse;
   logic pause_level;
   modport src (output adv_pulse, output pause_pulse, output pause_level);
   modport dst (input adv_pulse, input pause_pulse, input pause_level);
endinterface

// [ptic_trig_sync.sv]
// Trigger input synchroniser and rising edge detector
module ptic_trig_sync (
   input  wire logic clk,           // System clock
   input  wire logic sys_rst,       // Synchronous reset
   input  wire logic adv_raw,       // Advance trigger pin
   input  wire logic pause_raw,     // Pause trigger pin
   ptic_trig_if.src  trig           // Event outputs
);
   logic [1:0] meta_reg;
   logic [1:0] sync_reg;
   logic [1:0] prev_reg;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_reg <= 2'h0;
         sync_reg <= 2'h0;
         prev_reg <= 2'h0;
      end else begin
         meta_reg <= {pause_raw, adv_raw};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end
   // One pulse per rising edge, however long the pin stays high
   assign trig.adv_pulse   = sync_reg[0] & ~prev_reg[0];
   assign trig.pause_pulse = sync_reg[1] & ~prev_reg[1];
   assign trig.pause_level = sync_reg[1];
   one_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
      trig.adv_pulse |=> !trig.adv_pulse) else $error("advance pulse longer than one cycle");
endmodule

// [ptic_pwm.sv]
// Per channel current PWM generator with shared counter
module ptic_pwm #(
   parameter int W = 8,
   parameter int N = 3
) (
   input  wire logic             clk,     // System clock
   input  wire logic             sys_rst, // Synchronous reset
   input  wire logic [N*W-1:0]   duty,    // Duty per channel
   output logic      [N-1:0]     pwm      // Registered PWM outputs
);
   logic [W-1:0] cnt_reg;
   always_ff @(posedge clk) begin
      if (sys_rst) cnt_reg <= '0;
      else         cnt_reg <= cnt_reg + 1'b1;
   end
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         logic hi;
         assign hi = (cnt_reg < duty[g*W +: W]);
         always_ff @(posedge clk) begin
            if (sys_rst) pwm[g] <= 1'b0;
            else         pwm[g] <= hi;
         end
      end
   endgenerate
   zero_duty_a: assert property (@(posedge clk) disable iff (sys_rst)
      (duty[W-1:0] == '0) [*2] |-> !pwm[0]) else $error("pwm high at zero duty");
endmodule

// [ptic_top.sv]
// Pattern trigger and illumination controller top
// Contract
// - Three independent illumination channels, red, green and blue, are driven.
// - While healthy the alive blink output toggles continuously.
// - The fault indicator is at LED-off level during a fault, LED-on otherwise.
// - Each colour has its own current-setting PWM output.
// - Trigger outputs let peripherals synchronise with displayed patterns.
// - When external triggering is used the display timing follows the trigger inputs.
// - Under external triggering the first trigger input steps to the next pattern or toggles between two, per mode.
// - The second trigger input pauses the display while free running or steps by two under external triggering, per mode.
// - The exposure marker is high exactly while a pattern is exposed.
// - The first pattern marker is high while pattern zero is shown.
`include "ptic_cfg.svh"
module ptic_top
   import ptic_pkg::*;
#(
   parameter int          PW    = `PTIC_PWM_BITS,
   parameter int          PB    = `PTIC_PAT_BITS,
   parameter int unsigned BLINK = `PTIC_BLINK_HALF_CYC
) (
   input  wire logic                       clk,                      // Reference clock
   input  wire logic                       sys_rst,                  // Synchronous reset
   input  wire logic                       run_enable,               // Sequence running
   input  wire logic                       ext_trig_enable,          // Follow trigger inputs
   input  wire ptic_pkg::ptic_mode_t       trig_mode_cfg,            // Trigger mode
   input  wire logic [PB-1:0]              num_patterns,             // Sequence length
   input  wire logic [15:0]                expose_cycles,            // Exposure length
   input  wire logic [15:0]                gap_cycles,               // Dark gap length
   input  wire logic [2:0]                 color_enable_cfg,         // Per colour enable
   input  wire logic [PW-1:0]              red_duty,                 // Red current duty
   input  wire logic [PW-1:0]              green_duty,               // Green current duty
   input  wire logic [PW-1:0]              blue_duty,                // Blue current duty
   input  wire logic                       fault_in,                 // System fault
   input  wire logic                       advance_trigger_in,       // Trigger pin one
   input  wire logic                       pause_trigger_in,         // Trigger pin two
   output logic                            red_led_on,               // Red enable
   output logic                            green_led_on,             // Green enable
   output logic                            blue_led_on,              // Blue enable
   output logic                            red_current_pwm,          // Red PWM
   output logic                            green_current_pwm,        // Green PWM
   output logic                            blue_current_pwm,         // Blue PWM
   output logic                            alive_blink_out,          // Health blink
   output logic                            fault_led_out,            // High is LED on
   output logic                            exposure_marker_out,      // Exposure marker
   output logic                            first_pattern_marker_out, // First pattern marker
   output logic [PB-1:0]                   pattern_index             // Pattern shown
);
   import ptic_pkg::*;

   ptic_trig_if trig ();
   ptic_trig_sync u_sync (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .adv_raw   (advance_trigger_in),
      .pause_raw (pause_trigger_in),
      .trig      (trig)
   );

   // Fault is an asynchronous level from outside
   logic fault_meta_reg;
   logic fault_sync_reg;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_meta_reg <= 1'b0;
         fault_sync_reg <= 1'b0;
      end else begin
         fault_meta_reg <= fault_in;
         fault_sync_reg <= fault_meta_reg;
      end
   end

   // Health blink: frozen during a fault, so a stuck LED signals trouble
   logic [31:0] blink_cnt_reg;
   logic        blink_wrap;
   assign blink_wrap = (blink_cnt_reg >= BLINK - 1);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         blink_cnt_reg   <= 32'h0;
         alive_blink_out <= 1'b0;
         fault_led_out   <= 1'b0;
      end else begin
         fault_led_out <= ~fault_sync_reg;
         if (fault_sync_reg) begin
            blink_cnt_reg <= 32'h0;
         end else if (blink_wrap) begin
            blink_cnt_reg   <= 32'h0;
            alive_blink_out <= ~alive_blink_out;
         end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
         end
      end
   end

   // Pattern sequencer
   ptic_state_t   state_reg, state_next;
   ptic_mode_t    mode_reg;
   logic [15:0]   tcnt_reg;
   logic [PB-1:0] idx_reg, idx_next;
   logic          paused_reg;
   logic          pend_reg;       // Trigger seen, not yet acted on
   logic [PB-1:0] step_reg;       // Pending step amount
   logic          alt_reg;        // Alternating pattern selector
   logic [PB-1:0] last_idx;
   logic          timer_done;
   logic          step_ok;
   logic [PB:0]   idx_sum;
   logic          adv_act;
   logic          dbl_act;

   assign last_idx   = (num_patterns == '0) ? '0 : num_patterns - 1'b1;
   assign timer_done = (tcnt_reg == 16'h0);
   assign adv_act    = trig.adv_pulse & (mode_reg == PTIC_MODE_STEP);
   assign dbl_act    = trig.pause_pulse & (mode_reg == PTIC_MODE_ALT);
   // Free running steps unless paused; external triggers gate each pattern
   assign step_ok    = ext_trig_enable ? pend_reg : ~paused_reg;
   assign idx_sum    = {1'b0, idx_reg} + {1'b0, (ext_trig_enable ? step_reg : PB'(1))};
   assign idx_next   = (mode_reg == PTIC_MODE_ALT && !dbl_act && ext_trig_enable && !step_reg[1])
                       ? PB'(alt_reg)
                       : ((idx_sum > {1'b0, last_idx}) ? PB'(idx_sum - {1'b0, last_idx} - 1'b1)
                                                      : idx_sum[PB-1:0]);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         PTIC_ST_IDLE:   if (run_enable) state_next = PTIC_ST_EXPOSE;
         PTIC_ST_EXPOSE: if (timer_done) state_next = PTIC_ST_GAP;
         PTIC_ST_GAP:    if (!run_enable) state_next = PTIC_ST_IDLE;
                         else if (timer_done && step_ok) state_next = PTIC_ST_EXPOSE;
         default:        state_next = PTIC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg  <= PTIC_ST_IDLE;
         mode_reg   <= PTIC_MODE_STEP;
         tcnt_reg   <= 16'h0;
         idx_reg    <= '0;
         paused_reg <= 1'b0;
         pend_reg   <= 1'b0;
         step_reg   <= '0;
         alt_reg    <= 1'b0;
      end else begin
         state_reg <= state_next;
         // Pause toggles per pulse in step mode
         if (trig.pause_pulse && mode_reg == PTIC_MODE_STEP)
            paused_reg <= ~paused_reg;
         // Set wins over the consume below
         if (adv_act) begin
            pend_reg <= 1'b1;
            step_reg <= PB'(1);
         end else if (dbl_act) begin
            pend_reg <= 1'b1;
            step_reg <= PB'(2);
         end else if (trig.adv_pulse) begin
            pend_reg <= 1'b1;
            step_reg <= '0;
            alt_reg  <= ~alt_reg;
         end else if (state_reg == PTIC_ST_GAP && state_next == PTIC_ST_EXPOSE) begin
            pend_reg <= 1'b0;
         end
         if (state_reg != PTIC_ST_EXPOSE)
            mode_reg <= trig_mode_cfg;
         if (state_next == PTIC_ST_EXPOSE && state_reg != PTIC_ST_EXPOSE)
            tcnt_reg <= expose_cycles - 16'h1;
         else if (state_next == PTIC_ST_GAP && state_reg == PTIC_ST_EXPOSE)
            tcnt_reg <= gap_cycles;
         else if (!timer_done)
            tcnt_reg <= tcnt_reg - 16'h1;
         if (state_reg == PTIC_ST_IDLE)
            idx_reg <= '0;
         else if (state_reg == PTIC_ST_GAP && state_next == PTIC_ST_EXPOSE)
            idx_reg <= idx_next;
      end
   end

   // Outputs straight from flip-flops
   logic          expose_next;
   logic [2:0]    pwm_bits;
   logic [PB-1:0] idx_new;
   assign expose_next = (state_next == PTIC_ST_EXPOSE);
   // Next values, so index and first marker change together with the exposure marker
   assign idx_new     = (state_reg == PTIC_ST_IDLE) ? '0
                      : (state_reg == PTIC_ST_GAP && state_next == PTIC_ST_EXPOSE) ? idx_next
                      : idx_reg;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         exposure_marker_out      <= 1'b0;
         first_pattern_marker_out <= 1'b0;
         pattern_index            <= '0;
         red_led_on               <= 1'b0;
         green_led_on             <= 1'b0;
         blue_led_on              <= 1'b0;
         red_current_pwm          <= 1'b0;
         green_current_pwm        <= 1'b0;
         blue_current_pwm         <= 1'b0;
      end else begin
         exposure_marker_out      <= expose_next;
         // From next values; registering idx_reg would lag the exposure by a cycle
         first_pattern_marker_out <= (state_next != PTIC_ST_IDLE) && (idx_new == '0);
         pattern_index            <= idx_new;
         // LEDs lit only during exposure and without a fault
         red_led_on   <= color_enable_cfg[`PTIC_CH_RED] & expose_next & ~fault_sync_reg;
         green_led_on <= color_enable_cfg[`PTIC_CH_GREEN] & expose_next & ~fault_sync_reg;
         blue_led_on  <= color_enable_cfg[`PTIC_CH_BLUE] & expose_next & ~fault_sync_reg;
         red_current_pwm   <= pwm_bits[`PTIC_CH_RED];
         green_current_pwm <= pwm_bits[`PTIC_CH_GREEN];
         blue_current_pwm  <= pwm_bits[`PTIC_CH_BLUE];
      end
   end

   ptic_pwm #(.W(PW), .N(`PTIC_NUM_CH)) u_pwm (
      .clk     (clk),
      .sys_rst (sys_rst),
      .duty    ({blue_duty, green_duty, red_duty}),
      .pwm     (pwm_bits)
   );

   // Exposure and pattern markers
   expose_marker_a: assert property (@(posedge clk) disable iff (sys_rst)
      exposure_marker_out == (state_reg == PTIC_ST_EXPOSE))
      else $error("exposure marker out of step with exposure");
   first_mark_a: assert property (@(posedge clk) disable iff (sys_rst)
      first_pattern_marker_out == (state_reg != PTIC_ST_IDLE && idx_reg == '0))
      else $error("first pattern marker out of step");
   index_out_a: assert property (@(posedge clk) disable iff (sys_rst)
      pattern_index == idx_reg)
      else $error("pattern index output out of step");

   // Health and fault indicators
   fault_led_a: assert property (@(posedge clk) disable iff (sys_rst)
      fault_sync_reg |=> !fault_led_out) else $error("fault led not off in fault");
   fault_dark_a: assert property (@(posedge clk) disable iff (sys_rst)
      fault_sync_reg |=> !red_led_on && !green_led_on && !blue_led_on)
      else $error("led enabled during fault");
   blink_toggle_a: assert property (@(posedge clk) disable iff (sys_rst)
      !fault_sync_reg && blink_wrap |=> alive_blink_out != $past(alive_blink_out))
      else $error("health blink missed a toggle");
   blink_freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
      fault_sync_reg |=> $stable(alive_blink_out)) else $error("health blink moved in fault");

   // Channel outputs
   led_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      (red_led_on || green_led_on || blue_led_on) |-> exposure_marker_out)
      else $error("led on outside exposure");
   pwm_out_a: assert property (@(posedge clk) disable iff (sys_rst)
      red_current_pwm == $past(pwm_bits[`PTIC_CH_RED]))
      else $error("red pwm output not registered from generator");

   // Sequencer: a gap ends in exposure only when a step is allowed, or in idle once run is dropped
   sequence gap_done_s;
      state_reg == PTIC_ST_GAP && timer_done && run_enable;
   endsequence
   sequence expose_begin_s;
      state_reg == PTIC_ST_EXPOSE && exposure_marker_out;
   endsequence
   gap_advance_a: assert property (@(posedge clk) disable iff (sys_rst)
      gap_done_s ##0 step_ok |=> expose_begin_s) else $error("gap did not end in exposure");
   trig_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
      gap_done_s ##0 !step_ok |=> state_reg == PTIC_ST_GAP)
      else $error("gap ended with no step allowed");
   run_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
      state_reg == PTIC_ST_GAP && !run_enable
      |=> state_reg == PTIC_ST_IDLE && !exposure_marker_out)
      else $error("sequence did not stop");
   expose_end_a: assert property (@(posedge clk) disable iff (sys_rst)
      state_reg == PTIC_ST_EXPOSE && timer_done
      |=> state_reg == PTIC_ST_GAP && !exposure_marker_out)
      else $error("exposure did not end on time");
   pause_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      state_reg == PTIC_ST_GAP && !ext_trig_enable && paused_reg
      |=> state_reg != PTIC_ST_EXPOSE)
      else $error("exposure started while paused");
   free_step_a: assert property (@(posedge clk) disable iff (sys_rst)
      gap_done_s ##0 (step_ok && !ext_trig_enable && idx_reg < last_idx)
      |=> idx_reg == $past(idx_reg) + PB'(1)) else $error("free run did not step by one");
   wrap_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      gap_done_s ##0 (step_ok && !ext_trig_enable && idx_reg == last_idx)
      |=> idx_reg == '0) else $error("sequence did not wrap to the first pattern");

   // Trigger actions, one per synchronised edge
   sequence alt_adv_s;
      trig.adv_pulse && !dbl_act && mode_reg == PTIC_MODE_ALT;
   endsequence
   alt_toggle_a: assert property (@(posedge clk) disable iff (sys_rst)
      alt_adv_s |=> alt_reg != $past(alt_reg) && pend_reg && step_reg == '0)
      else $error("alternate trigger did not toggle");
   step_one_a: assert property (@(posedge clk) disable iff (sys_rst)
      adv_act |=> pend_reg && step_reg == PB'(1)) else $error("advance trigger not held");
   double_step_a: assert property (@(posedge clk) disable iff (sys_rst)
      dbl_act |=> pend_reg && step_reg == PB'(2)) else $error("double step not held");
   pause_toggle_a: assert property (@(posedge clk) disable iff (sys_rst)
      trig.pause_pulse && mode_reg == PTIC_MODE_STEP |=> paused_reg != $past(paused_reg))
      else $error("pause trigger did not toggle pause");
   pend_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      state_reg == PTIC_ST_GAP && state_next == PTIC_ST_EXPOSE && !trig.adv_pulse && !dbl_act
      |=> !pend_reg) else $error("trigger acted on twice");
   mode_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state_reg == PTIC_ST_EXPOSE) && $past(state_reg == PTIC_ST_EXPOSE) |-> $stable(mode_reg))
      else $error("mode changed during exposure");
   mode_sample_a: assert property (@(posedge clk) disable iff (sys_rst)
      state_reg != PTIC_ST_EXPOSE |=> mode_reg == $past(trig_mode_cfg))
      else $error("mode not sampled between patterns");
endmodule

// [ptic_trig_partner.sv]
// Behavioural external trigger processor driving the two trigger pins
module ptic_trig_partner #(
   parameter int HOLD = 6
) (
   input  wire logic clk,        // Reference clock
   input  wire logic fire_adv,   // Request an advance pulse
   input  wire logic fire_pause, // Request a pause pulse
   output logic      adv_pin,    // Trigger pin one
   output logic      pause_pin   // Trigger pin two
);
   timeunit 1ns;
   timeprecision 1ps;
   int adv_cnt = 0;
   int pause_cnt = 0;
   // Pulses span several cycles, so a level held long must still act once
   always @(posedge clk) begin
      if (fire_adv) adv_cnt <= HOLD;
      else if (adv_cnt > 0) adv_cnt <= adv_cnt - 1;
      if (fire_pause) pause_cnt <= HOLD;
      else if (pause_cnt > 0) pause_cnt <= pause_cnt - 1;
   end
   assign adv_pin = (adv_cnt > 0);
   assign pause_pin = (pause_cnt > 0);
endmodule

// [ptic_tb.sv]
// Self-checking testbench for the pattern trigger and illumination controller
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
   $display("BAD %0t got %0h expected %0h", $time, got, exp); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ptic_pkg::*;
   logic        clk = 1'b0, sys_rst = 1'b1, run_enable = 1'b0, ext_trig_enable = 1'b0;
   ptic_mode_t  trig_mode_cfg = PTIC_MODE_STEP;
   logic [7:0]  num_patterns = 8'h05;
   logic [15:0] expose_cycles = 16'h0014, gap_cycles = 16'h0008;
   logic [2:0]  color_enable_cfg = 3'h0;
   logic [7:0]  duty [3] = '{8'h00, 8'h00, 8'h00};
   logic        fault_in = 1'b0, fire_adv = 1'b0, fire_pause = 1'b0;
   logic        adv_pin, pause_pin, alive, fault_led, expo, first_m;
   wire  [2:0]  led_on, pwm;
   logic [7:0]  pidx, idx_at, prev;
   logic        first_at;
   int          width_at, n_fail = 0, check_count = 0;
   int          led_cnt [3];
   logic [31:0] lfsr_state = 32'he1673500, r;

   always #10 clk = ~clk;

   ptic_trig_partner ptic_trig_partner_i (.clk(clk), .fire_adv(fire_adv),
      .fire_pause(fire_pause), .adv_pin(adv_pin), .pause_pin(pause_pin));

   // Short blink period keeps the health check inside a few dozen cycles
   ptic_top #(.BLINK(4)) ptic_top_i (.clk(clk), .sys_rst(sys_rst), .run_enable(run_enable),
      .ext_trig_enable(ext_trig_enable), .trig_mode_cfg(trig_mode_cfg),
      .num_patterns(num_patterns), .expose_cycles(expose_cycles), .gap_cycles(gap_cycles),
      .color_enable_cfg(color_enable_cfg), .red_duty(duty[0]), .green_duty(duty[1]),
      .blue_duty(duty[2]), .fault_in(fault_in), .advance_trigger_in(adv_pin),
      .pause_trigger_in(pause_pin), .red_led_on(led_on[0]), .green_led_on(led_on[1]),
      .blue_led_on(led_on[2]), .red_current_pwm(pwm[0]), .green_current_pwm(pwm[1]),
      .blue_current_pwm(pwm[2]), .alive_blink_out(alive), .fault_led_out(fault_led),
      .exposure_marker_out(expo), .first_pattern_marker_out(first_m), .pattern_index(pidx));

   function automatic logic [31:0] rnd();
      lfsr_state = {lfsr_state[30:0], ^(lfsr_state & 32'h80200003)};
      return lfsr_state;
   endfunction

   function automatic logic [7:0] next_idx(input logic [7:0] i, input int step);
      return 8'((int'(i) + step) % int'(num_patterns));
   endfunction

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Waits for one whole exposure, sampling on the falling edge
   task automatic wait_expose();
      int k;
      k = 0;
      led_cnt = '{0, 0, 0};
      while (k < 3000 && expo !== 1'b0) begin @(negedge clk); k++; end
      while (k < 3000 && expo !== 1'b1) begin @(negedge clk); k++; end
      idx_at = pidx;
      first_at = first_m;
      width_at = 0;
      while (k < 3000 && expo === 1'b1) begin
         for (int c = 0; c < 3; c++) led_cnt[c] += (led_on[c] === 1'b1);
         width_at++;
         k++;
         @(negedge clk);
      end
      if (k >= 3000) begin
         n_fail++;
         $display("BAD %0t exposure wait ran out", $time);
         end_of_test();
      end
   endtask

   task automatic count_blink(output int t);
      logic last;
      t = 0;
      @(negedge clk);
      last = alive;
      repeat (40) begin @(negedge clk); t += (alive !== last); last = alive; end
   endtask

   // One request to the partner; it stretches the pin over several cycles
   task automatic pulse(input logic use_pause);
      @(posedge clk);
      if (use_pause) fire_pause <= 1'b1;
      else fire_adv <= 1'b1;
      @(posedge clk);
      fire_adv <= 1'b0;
      fire_pause <= 1'b0;
   endtask

   // Gap must hold with no trigger, then one pulse moves exactly once
   task automatic trig_step(input logic use_pause, input logic [7:0] exp_idx);
      int hits;
      hits = 0;
      repeat (60) begin @(negedge clk); hits += (expo === 1'b1); end
      `CHK(hits, 0);
      pulse(use_pause);
      wait_expose();
      `CHK(idx_at, exp_idx);
   endtask

   initial begin
      int t, cnt [3];
      repeat (2) @(negedge clk);
      `CHK({expo, first_m, alive, led_on, pwm}, 9'h000);
      repeat (1) @(posedge clk);
      sys_rst <= 1'b0;
      for (int rd = 0; rd < 2; rd++) begin
         @(posedge clk);
         r = rnd();
         duty[0] <= (rd == 0) ? 8'h00 : r[7:0];
         duty[1] <= (rd == 0) ? 8'hff : r[15:8];
         duty[2] <= r[23:16];
         repeat (300) @(posedge clk);
         cnt = '{0, 0, 0};
         repeat (256) begin
            @(negedge clk);
            for (int c = 0; c < 3; c++) cnt[c] += (pwm[c] === 1'b1);
         end
         for (int c = 0; c < 3; c++) `CHK(cnt[c], int'(duty[c]));
      end
      @(posedge clk);
      r = rnd();
      num_patterns <= 8'(3 + r[1:0]);
      color_enable_cfg <= r[6:4];
      run_enable <= 1'b1;
      wait_expose();
      for (int i = 0; i < 2 * int'(num_patterns); i++) begin
         prev = idx_at;
         wait_expose();
         `CHK(idx_at, next_idx(prev, 1));
         `CHK(first_at, (idx_at == 8'h00));
         `CHK((width_at >= expose_cycles) && (width_at <= expose_cycles + 2), 1'b1);
         for (int c = 0; c < 3; c++) `CHK(led_cnt[c] != 0, color_enable_cfg[c]);
      end
      count_blink(t);
      `CHK((t >= 9) && (t <= 11), 1'b1);
      @(posedge clk);
      fault_in <= 1'b1;
      repeat (8) @(negedge clk);
      `CHK({fault_led, led_on}, 4'h0);
      count_blink(t);
      `CHK(t, 0);
      @(posedge clk);
      fault_in <= 1'b0;
      repeat (8) @(negedge clk);
      `CHK(fault_led, 1'b1);
      wait_expose();
      // Step mode, free running: one pause pulse holds the gap, the next resumes
      pulse(1'b1);
      trig_step(1'b1, next_idx(idx_at, 1));
      @(posedge clk);
      ext_trig_enable <= 1'b1;
      for (int k = 0; k < 8 && (k < 2 || idx_at !== 8'h00); k++) begin
         trig_step(1'b0, next_idx(idx_at, 1));
      end
      @(posedge clk);
      trig_mode_cfg <= PTIC_MODE_ALT;
      trig_step(1'b0, 8'h01);
      trig_step(1'b0, 8'h00);
      trig_step(1'b1, next_idx(8'h00, 2));
      end_of_test();
   end
endmodule
